// ### verilog/ccl_regs.sv
/*
 * usb charger register bank: i2c slave, registers 04..07, charge current
 * clamp and indicator blinker.
 * assumes scl/sda already synchronous to clk_i and slow against 25 MHz;
 * the bench resolves the open-drain sda wire from sda_oe_n_o.
 */
`timescale 1ns/1ns
module ccl_regs #(
	parameter int unsigned TICK_CYCLES = ccl_pkg::LED_TICK_CYC
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output wire logic             sda_o,
	output wire logic             sda_oe_n_o,
	input  wire logic             usb_supply_detect_i,
	input  wire logic             power_mgmt_active_flag_i,
	input  wire logic             ac_supply_detect_i,
	input  wire logic             charging_active_i,
	output      logic             charger_reset_o,
	output      ccl_pkg::ccl_chg_s chg_ctrl_o,
	output      logic [1:0]       indicator_current_code_o,
	output      logic             indicator_drive_o
);
	ccl_pkg::ccl_state_e state_reg, state_next;
	logic [7:0] chg_reg, spv_reg, lim_reg, led_reg;
	logic       lim_locked_reg;
	logic       scl_d_reg, sda_d_reg;
	logic [7:0] sh_reg;
	logic [3:0] bit_reg;
	logic [1:0] phase_reg;
	logic       rw_reg, ack_ok_reg, drv_low_reg;
	logic [7:0] ptr_reg;
	logic [17:0] tb_reg;
	logic [8:0] ph_cnt_reg;
	logic       ph_on_reg;
	logic [3:0] tfield_reg;

	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input logic [7:0] c, input logic [7:0] s, input logic [7:0] l,
		input logic [7:0] e, input logic u, input logic d, input logic v);
		read_mux = 8'h00;
		if (a == ccl_pkg::REG_CHG) begin
			read_mux = c & ccl_pkg::CHG_WR_MASK;
		end else if (a == ccl_pkg::REG_SPV) begin
			read_mux = s & ccl_pkg::SPV_WR_MASK;
			read_mux[ccl_pkg::USB_B] = u;
			read_mux[ccl_pkg::PM_B] = d;
			read_mux[ccl_pkg::AC_B] = v;
		end else if (a == ccl_pkg::REG_LIM) begin
			read_mux = l;
		end else if (a == ccl_pkg::REG_LED) begin
			read_mux = e & ccl_pkg::LED_WR_MASK;
		end
	endfunction : read_mux

	function automatic logic [8:0] led_len(input logic [1:0] c,
		input logic on);
		led_len = ccl_pkg::OFF3_T;
		if (on) begin
			unique case (c)
				2'h0: led_len = ccl_pkg::ON0_T;
				2'h1: led_len = ccl_pkg::ON1_T;
				default: led_len = ccl_pkg::ON2_T;
			endcase
		end else begin
			unique case (c)
				2'h0: led_len = ccl_pkg::OFF0_T;
				2'h1: led_len = ccl_pkg::OFF1_T;
				2'h2: led_len = ccl_pkg::OFF2_T;
				default: led_len = ccl_pkg::OFF3_T;
			endcase
		end
	endfunction : led_len

	// bus events
	wire scl_rise = scl_i & ~scl_d_reg;
	wire scl_fall = ~scl_i & scl_d_reg;
	wire start_ev = scl_i & scl_d_reg & sda_d_reg & ~sda_i;
	wire stop_ev  = scl_i & scl_d_reg & ~sda_d_reg & sda_i;
	wire byte_end = (state_reg == ccl_pkg::ST_RX) & scl_fall
		& (bit_reg == 4'h8);
	wire addr_hit = (sh_reg[7:1] == ccl_pkg::I2C_ADDR);
	wire wr_data  = byte_end & (phase_reg == 2'h2);
	wire wr_chg   = wr_data & (ptr_reg == ccl_pkg::REG_CHG);
	wire wr_spv   = wr_data & (ptr_reg == ccl_pkg::REG_SPV);
	wire wr_lim   = wr_data & (ptr_reg == ccl_pkg::REG_LIM)
		& ~lim_locked_reg;
	wire wr_led   = wr_data & (ptr_reg == ccl_pkg::REG_LED);
	wire [7:0] rd_data = read_mux(ptr_reg, chg_reg, spv_reg, lim_reg,
		led_reg, usb_supply_detect_i, power_mgmt_active_flag_i,
		ac_supply_detect_i);
	wire tx_load  = (state_reg == ccl_pkg::ST_RACK) & scl_fall & rw_reg
		| (state_reg == ccl_pkg::ST_TACK) & scl_fall & ack_ok_reg;
	wire tx_done  = (state_reg == ccl_pkg::ST_TX) & scl_fall
		& (bit_reg == 4'h7);

	// only a low is ever driven; a one is the released wire
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~drv_low_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ccl_pkg::ST_IDLE: state_next = ccl_pkg::ST_IDLE;
			ccl_pkg::ST_RX: begin
				if (byte_end) begin
					state_next = (phase_reg != 2'h0 || addr_hit)
						? ccl_pkg::ST_RACK : ccl_pkg::ST_IDLE;
				end
			end
			ccl_pkg::ST_RACK: begin
				if (scl_fall) begin
					state_next = rw_reg ? ccl_pkg::ST_TX : ccl_pkg::ST_RX;
				end
			end
			ccl_pkg::ST_TX: begin
				if (tx_done) begin
					state_next = ccl_pkg::ST_TACK;
				end
			end
			ccl_pkg::ST_TACK: begin
				if (scl_fall) begin
					state_next = ack_ok_reg ? ccl_pkg::ST_TX
						: ccl_pkg::ST_IDLE;
				end
			end
			default: state_next = ccl_pkg::ST_IDLE;
		endcase
		if (start_ev) begin
			state_next = ccl_pkg::ST_RX;
		end else if (stop_ev) begin
			state_next = ccl_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= ccl_pkg::ST_IDLE;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sh_reg <= 8'h00;
			bit_reg <= 4'h0;
			phase_reg <= 2'h0;
			rw_reg <= 1'b0;
			ack_ok_reg <= 1'b0;
			drv_low_reg <= 1'b0;
			ptr_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			scl_d_reg <= scl_i;
			sda_d_reg <= sda_i;
			if (start_ev) begin
				bit_reg <= 4'h0;
				phase_reg <= 2'h0;
				rw_reg <= 1'b0;
				drv_low_reg <= 1'b0;
			end else if (stop_ev) begin
				drv_low_reg <= 1'b0;
			end else if (state_reg == ccl_pkg::ST_RX) begin
				if (scl_rise) begin
					sh_reg <= {sh_reg[6:0], sda_i};
					bit_reg <= bit_reg + 4'h1;
				end
				if (byte_end) begin
					drv_low_reg <= (phase_reg != 2'h0) | addr_hit;
					if (phase_reg == 2'h0) begin
						rw_reg <= sh_reg[0];
						phase_reg <= 2'h1;
					end else if (phase_reg == 2'h1) begin
						ptr_reg <= sh_reg;
						phase_reg <= 2'h2;
					end else begin
						ptr_reg <= ptr_reg + 8'h01;
					end
				end
			end else if (state_reg == ccl_pkg::ST_RACK) begin
				if (scl_fall) begin
					bit_reg <= 4'h0;
					drv_low_reg <= rw_reg & ~rd_data[7];
				end
			end else if (state_reg == ccl_pkg::ST_TX) begin
				if (scl_fall) begin
					bit_reg <= bit_reg + 4'h1;
					drv_low_reg <= ~tx_done & ~sh_reg[6];
					sh_reg <= {sh_reg[6:0], 1'b0};
					if (tx_done) begin
						ptr_reg <= ptr_reg + 8'h01;
					end
				end
			end else if (state_reg == ccl_pkg::ST_TACK) begin
				if (scl_rise) begin
					ack_ok_reg <= ~sda_i;
				end
				if (tx_load) begin
					bit_reg <= 4'h0;
					drv_low_reg <= ~rd_data[7];
				end
			end
			if (tx_load) begin
				sh_reg <= rd_data;
			end
		end
	end

	// register bank
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			chg_reg <= ccl_pkg::CHG_RST;
			spv_reg <= ccl_pkg::SPV_RST;
			lim_reg <= ccl_pkg::LIM_RST;
			led_reg <= ccl_pkg::LED_RST;
			lim_locked_reg <= 1'b0;
			charger_reset_o <= 1'b0;
		end else begin
			charger_reset_o <= wr_chg & sh_reg[ccl_pkg::CHG_RESET_B];
			if (wr_chg) begin
				chg_reg <= sh_reg & ccl_pkg::CHG_WR_MASK;
			end
			if (wr_spv) begin
				spv_reg <= sh_reg & ccl_pkg::SPV_WR_MASK;
			end
			if (wr_lim) begin
				lim_reg <= sh_reg;
				lim_locked_reg <= 1'b1;
			end
			if (wr_led) begin
				led_reg <= sh_reg & ccl_pkg::LED_WR_MASK;
			end
		end
	end

	// charge control outputs
	wire [3:0] fast_code = {1'b0,
		chg_reg[ccl_pkg::FAST_MSB:ccl_pkg::FAST_LSB]};
	wire [3:0] lim_code = lim_reg[ccl_pkg::LIM_I_MSB:ccl_pkg::LIM_I_LSB];
	wire [3:0] usb_code = (fast_code > ccl_pkg::USB_MAX_CODE)
		? ccl_pkg::USB_MAX_CODE : fast_code;
	wire [3:0] eff_code = (usb_code > lim_code) ? lim_code : usb_code;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			chg_ctrl_o <= '0;
		end else begin
			chg_ctrl_o.reduced <= spv_reg[ccl_pkg::REDUCED_B];
			chg_ctrl_o.sense_code <= eff_code;
			chg_ctrl_o.term_code <= chg_reg[ccl_pkg::TERM_MSB:0];
			chg_ctrl_o.special_volt <= spv_reg[ccl_pkg::SPV_MSB:0];
			chg_ctrl_o.max_reg_volt <= lim_reg[ccl_pkg::LIM_V_MSB:0];
		end
	end

	// indicator blinker on a slow timebase; restart avoids a stale phase
	wire [1:0] on_code  = led_reg[ccl_pkg::LED_ON_MSB:ccl_pkg::LED_ON_LSB];
	wire [1:0] off_code = led_reg[ccl_pkg::LED_OFF_MSB:0];
	wire [1:0] i_code   = led_reg[ccl_pkg::LED_I_MSB:ccl_pkg::LED_I_LSB];
	wire led_en = (i_code != 2'h0) & (led_reg[ccl_pkg::LED_FOLLOW_B]
		| charging_active_i);
	wire restart = ({on_code, off_code} != tfield_reg);
	wire tick = (tb_reg == 18'(TICK_CYCLES - 1));
	wire [8:0] ph_len = led_len(ph_on_reg ? on_code : off_code,
		ph_on_reg);
	wire ph_end = tick & (ph_cnt_reg + 9'h001 >= ph_len);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tb_reg <= 18'h00000;
			ph_cnt_reg <= 9'h000;
			ph_on_reg <= 1'b1;
			tfield_reg <= ccl_pkg::LED_RST[3:0];
			indicator_drive_o <= 1'b0;
			indicator_current_code_o <= 2'h0;
		end else begin
			tb_reg <= tick ? 18'h00000 : tb_reg + 18'h00001;
			tfield_reg <= {on_code, off_code};
			indicator_current_code_o <= i_code;
			if (!led_en || restart) begin
				ph_cnt_reg <= 9'h000;
				ph_on_reg <= 1'b1;
			end else if (ph_end) begin
				ph_cnt_reg <= 9'h000;
				ph_on_reg <= ~ph_on_reg;
			end else if (tick) begin
				ph_cnt_reg <= ph_cnt_reg + 9'h001;
			end
			indicator_drive_o <= led_en
				& ((on_code == ccl_pkg::ON_CONST) | ph_on_reg);
		end
	end

	chk_reset_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_chg && sh_reg[7] |=> charger_reset_o ##1 !charger_reset_o)
		else $error("charger reset pulse wrong");
	chk_reset_reads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ptr_reg == ccl_pkg::REG_CHG |-> !rd_data[7])
		else $error("reset bit read as one");
	chk_current_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		##1 chg_ctrl_o.sense_code <= 4'h7
		&& chg_ctrl_o.sense_code <= $past(lim_code))
		else $error("charge code above clamp");
	chk_usb_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ptr_reg == ccl_pkg::REG_SPV |-> rd_data[6] == usb_supply_detect_i
		&& rd_data[4] == power_mgmt_active_flag_i)
		else $error("status bits misread");
	chk_reduced_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_spv ##1 1'b1 |=> chg_ctrl_o.reduced == $past(sh_reg[5], 2))
		else $error("reduced select not applied");
	chk_limit_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		lim_locked_reg |=> $stable(lim_reg) && lim_locked_reg)
		else $error("safety limit rewritten");
	chk_led_const: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		led_en && on_code == 2'h3 |=> indicator_drive_o)
		else $error("constant on not lit");
	chk_led_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!led_en |=> !indicator_drive_o)
		else $error("led lit while disabled");
	chk_addr_nack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		byte_end && phase_reg == 2'h0 && !addr_hit |=> sda_oe_n_o [*2])
		else $error("foreign address acknowledged");
	chk_blink_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		led_en && restart |=> ph_on_reg && ph_cnt_reg == 9'h000)
		else $error("blink not restarted");
endmodule : ccl_regs

// ### verilog/ccl_pkg.sv
/*
 * constants, register map, field layout and types for the usb charger
 * register bank with its indicator blinker.
 * assumes one 25 MHz clock and a synchronous active-low reset.
 */
package ccl_pkg;
	localparam logic [6:0] I2C_ADDR     = 7'h6B;
	localparam logic [7:0] REG_CHG      = 8'h04;
	localparam logic [7:0] REG_SPV      = 8'h05;
	localparam logic [7:0] REG_LIM      = 8'h06;
	localparam logic [7:0] REG_LED      = 8'h07;
	localparam logic [7:0] CHG_RST      = 8'h01;
	localparam logic [7:0] SPV_RST      = 8'h24;
	localparam logic [7:0] LIM_RST      = 8'h40;
	localparam logic [7:0] LED_RST      = 8'h82;
	localparam logic [7:0] CHG_WR_MASK  = 8'h7F;
	localparam logic [7:0] SPV_WR_MASK  = 8'hA7;
	localparam logic [7:0] LED_WR_MASK  = 8'hDF;
	localparam int         CHG_RESET_B  = 7;
	localparam int         FAST_MSB     = 6;
	localparam int         FAST_LSB     = 4;
	localparam int         TERM_MSB     = 2;
	localparam int         USB_B        = 6;
	localparam int         REDUCED_B    = 5;
	localparam int         PM_B         = 4;
	localparam int         AC_B         = 3;
	localparam int         SPV_MSB      = 2;
	localparam int         LIM_I_MSB    = 7;
	localparam int         LIM_I_LSB    = 4;
	localparam int         LIM_V_MSB    = 3;
	localparam int         LED_I_MSB    = 7;
	localparam int         LED_I_LSB    = 6;
	localparam int         LED_FOLLOW_B = 4;
	localparam int         LED_ON_MSB   = 3;
	localparam int         LED_ON_LSB   = 2;
	localparam int         LED_OFF_MSB  = 1;
	// 1.25 A on 68 mOhm is 85.0 mV = 37.4 mV + 7 steps of 6.8 mV
	localparam logic [3:0] USB_MAX_CODE = 4'h7;
	localparam int         CLK_HZ       = 25000000;
	localparam int         LED_TICK_MS  = 10;
	localparam int         LED_TICK_CYC = CLK_HZ / 1000 * LED_TICK_MS;
	localparam int         ON0_MS       = 130;
	localparam int         ON1_MS       = 260;
	localparam int         ON2_MS       = 520;
	localparam int         OFF0_MS      = 390;
	localparam int         OFF1_MS      = 780;
	localparam int         OFF2_MS      = 1560;
	localparam int         OFF3_MS      = 3120;
	localparam logic [8:0] ON0_T        = 9'(ON0_MS / LED_TICK_MS);
	localparam logic [8:0] ON1_T        = 9'(ON1_MS / LED_TICK_MS);
	localparam logic [8:0] ON2_T        = 9'(ON2_MS / LED_TICK_MS);
	localparam logic [8:0] OFF0_T       = 9'(OFF0_MS / LED_TICK_MS);
	localparam logic [8:0] OFF1_T       = 9'(OFF1_MS / LED_TICK_MS);
	localparam logic [8:0] OFF2_T       = 9'(OFF2_MS / LED_TICK_MS);
	localparam logic [8:0] OFF3_T       = 9'(OFF3_MS / LED_TICK_MS);
	localparam logic [1:0] ON_CONST     = 2'h3;

	typedef struct packed {
		logic       reduced;
		logic [3:0] sense_code;
		logic [2:0] term_code;
		logic [2:0] special_volt;
		logic [3:0] max_reg_volt;
	} ccl_chg_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_RACK = 5'h04,
		ST_TX   = 5'h08,
		ST_TACK = 5'h10
	} ccl_state_e;
endpackage : ccl_pkg

// ### test/ccl_host_model.sv
/* i2c host model: drives scl and an open-drain pull on sda.
 * assumes the bench resolves sda with a pull-up from all pulls. */
`timescale 1ns/1ns
module ccl_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output      logic scl_o,
	output      logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// third of a bit, 4 clk, keeps each scl half period above the minimum
	task automatic q(input logic c, input logic l);
		scl_o <= c;
		sda_low_o <= l;
		repeat (4) @(posedge clk_i);
	endtask : q
	// data moves only while scl is low, so no false start or stop
	task automatic bit_io(input logic b, output logic r);
		q(1'b0, sda_low_o);
		q(1'b0, ~b);
		q(1'b1, ~b);
		r = sda_i;
	endtask : bit_io
	// scl drops first so a slave still holding its ack lets go
	task automatic start();
		q(1'b0, sda_low_o);
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b1);
	endtask : start
	task automatic stop();
		q(1'b0, sda_low_o);
		q(1'b0, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
	endtask : stop
	task automatic xfer(input logic [7:0] tx, input logic mack,
		output logic [7:0] rx, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(mack, nak);
	endtask : xfer
	task automatic wr(input logic [6:0] dev, input logic [7:0] p,
		input logic [7:0] d, output logic ok);
		logic [7:0] x;
		logic       n0, n1, n2;
		start();
		xfer({dev, 1'b0}, 1'b1, x, n0);
		xfer(p, 1'b1, x, n1);
		xfer(d, 1'b1, x, n2);
		stop();
		ok = ~(n0 | n1 | n2);
	endtask : wr
	task automatic rd(input logic [6:0] dev, input logic [7:0] p,
		output logic [7:0] d, output logic ok);
		logic [7:0] x;
		logic       n0, n1, n2, n3;
		start();
		xfer({dev, 1'b0}, 1'b1, x, n0);
		xfer(p, 1'b1, x, n1);
		start();
		xfer({dev, 1'b1}, 1'b1, x, n2);
		xfer(8'hFF, 1'b1, d, n3);
		stop();
		ok = ~(n0 | n1 | n2);
	endtask : rd
endmodule : ccl_host_model

// ### test/ccl_regs_tb_top.sv
/* bench for the charger register bank: host model on i2c, live status
 * inputs, integer register model, blinker timing.
 * assumes the tick divider is cut to 4 clk for simulation. */
`timescale 1ns/1ns
module ccl_regs_tb_top;
	localparam int TICK = 4;
	logic              clk_i, rst_n_i, scl, host_low, sda_w, sda_o, oe_n;
	logic              usb, pm, ac, chg_act, chg_rst, led;
	logic [1:0]        led_i;
	logic [7:0]        d;
	logic              ok;
	ccl_pkg::ccl_chg_s chg;
	int                err_total, n_tests, seed, pulses, exp_pulses, n;
	int                m4, m5, m6, m7, locked;
	int                on_ms[3] = '{130, 260, 520};
	int                off_ms[4] = '{390, 780, 1560, 3120};

	assign sda_w = ~host_low & (oe_n | sda_o);
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	ccl_regs #(.TICK_CYCLES(TICK)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(oe_n),
		.usb_supply_detect_i(usb), .power_mgmt_active_flag_i(pm),
		.ac_supply_detect_i(ac), .charging_active_i(chg_act),
		.charger_reset_o(chg_rst), .chg_ctrl_o(chg),
		.indicator_current_code_o(led_i), .indicator_drive_o(led));
	ccl_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(host_low));
	always @(posedge clk_i) if (chg_rst === 1'b1) pulses++;

	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [15:0] seen, input int e, string w);
		n_tests++;
		if (seen !== 16'(e)) begin
			err_total++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, w, seen, e);
		end
	endtask : check
	function automatic int rexp(input int p);
		case (p)
			4: return m4;
			5: return m5 | (usb << 6) | (pm << 4) | (ac << 3);
			6: return m6;
			7: return m7;
			default: return 0;
		endcase
	endfunction : rexp
	task automatic put(input logic [7:0] p, input logic [7:0] v);
		host.wr(ccl_pkg::I2C_ADDR, p, v, ok);
		check({15'h0, ok}, 1, "write ack");
		case (p)
			8'h04: m4 = v & 8'h7F;
			8'h05: m5 = v & 8'hA7;
			8'h07: m7 = v & 8'hDF;
			8'h06: if (locked == 0) begin
				m6 = v;
				locked = 1;
			end
			default: ;
		endcase
		exp_pulses += (p == 8'h04 && v[7]);
	endtask : put
	task automatic rd_chk(input logic [7:0] p, string w);
		host.rd(ccl_pkg::I2C_ADDR, p, d, ok);
		check({ok, d}, 256 + rexp(p), w);
	endtask : rd_chk
	task automatic chg_chk();
		int s;
		s = (m4 >> 4) & 7;
		if (s > ccl_pkg::USB_MAX_CODE) s = ccl_pkg::USB_MAX_CODE;
		if (s > (m6 >> 4)) s = m6 >> 4;
		check({1'b0, chg}, (((m5 >> 5) & 1) << 14) | (s << 10) |
			((m4 & 7) << 7) | ((m5 & 7) << 4) | (m6 & 15), "outputs");
	endtask : chg_chk
	task automatic hold(input logic v, string w);
		n = 0;
		repeat (2) @(posedge clk_i);
		repeat (100) begin
			@(posedge clk_i);
			#1;
			n += (led === v);
		end
		check(16'(n), 100, w);
	endtask : hold
	// bounded wait so a stuck blinker shows up as a wrong length
	task automatic lvl(input logic v);
		n = 0;
		while (led !== v && n < 5000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask : lvl

	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		summarize();
	end
	initial begin
		{rst_n_i, usb, pm, ac, chg_act} = 5'h00;
		seed = 17;
		{m4, m5, m6, m7, locked} = {32'h01, 32'h24, 32'h40, 32'h82, 32'h0};
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int p = 4; p < 9; p++) rd_chk(p[7:0], "reset");
		chg_chk();
		$display("reset values done");
		d = {4'h5, 4'($random(seed))};
		put(ccl_pkg::REG_LIM, d);
		put(ccl_pkg::REG_LIM, ~d);
		rd_chk(ccl_pkg::REG_LIM, "limit");
		for (int k = 0; k < 6; k++) begin
			d = 8'($random(seed));
			if (k == 0) d[7] = 1'b1;
			put(ccl_pkg::REG_CHG, d);
			rd_chk(ccl_pkg::REG_CHG, "charge reg");
			chg_chk();
		end
		check(16'(pulses), exp_pulses, "reset pulses");
		$display("charge and limit done");
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			{usb, pm, ac} <= 3'(k);
			put(ccl_pkg::REG_SPV, 8'($random(seed)));
			rd_chk(ccl_pkg::REG_SPV, "status");
			chg_chk();
		end
		host.wr(7'h6A, ccl_pkg::REG_LED, 8'h00, ok);
		check({15'h0, ok}, 0, "foreign addr");
		rd_chk(ccl_pkg::REG_LED, "led kept");
		$display("status and address done");
		for (int c = 0; c < 4; c++) begin
			put(ccl_pkg::REG_LED, {2'(c), 6'h32});
			check({14'h0, led_i}, c, "led current");
		end
		rd_chk(ccl_pkg::REG_LED, "led reg");
		put(ccl_pkg::REG_LED, 8'h8F);
		hold(1'b0, "dark idle");
		@(posedge clk_i);
		chg_act <= 1'b1;
		hold(1'b1, "constant on");
		@(posedge clk_i);
		chg_act <= 1'b0;
		put(ccl_pkg::REG_LED, 8'h9F);
		hold(1'b1, "follow lit");
		put(ccl_pkg::REG_LED, 8'h1F);
		hold(1'b0, "current off");
		for (int k = 0; k < 4; k++) begin
			put(ccl_pkg::REG_LED, {4'h9, 2'(k % 3), 2'(k)});
			lvl(1'b0);
			lvl(1'b1);
			check(16'(n), off_ms[k] / ccl_pkg::LED_TICK_MS * TICK, "off");
			lvl(1'b0);
			check(16'(n), on_ms[k % 3] / ccl_pkg::LED_TICK_MS * TICK, "on");
		end
		$display("indicator done");
		// a second reset must unlock the safety limit for one more write
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		{m4, m5, m6, m7, locked} = {32'h01, 32'h24, 32'h40, 32'h82, 32'h0};
		@(posedge clk_i);
		rd_chk(ccl_pkg::REG_LED, "led after reset");
		put(ccl_pkg::REG_LIM, 8'h3C);
		rd_chk(ccl_pkg::REG_LIM, "limit relock");
		$display("second reset done");
		summarize();
	end
endmodule : ccl_regs_tb_top
